// *** accel_ctl_regs.svh ***
// register offsets, field positions and timing counts of the control and status bank
`ifndef ACCEL_CTL_REGS_SVH
`define ACCEL_CTL_REGS_SVH

`define ADDR_DEVICE_CONDITION   8'h05
`define ADDR_SOURCE_ENABLE      8'h06
`define ADDR_STATE_SELECT       8'h07
`define ADDR_RATE_SELECT        8'h08
`define ADDR_MOTION_CTRL        8'h09
`define ADDR_PENDING_STATUS     8'h14

`define RST_BYTE                8'h00
`define RST_RATE                3'h0
`define RST_STATE               2'h0

`define COND_BUSY_BIT           7
`define COND_STALL_BIT          4
`define COND_RES_BIT            2

`define EN_TILT_BIT             0
`define EN_FLIP_BIT             1
`define EN_MOVE_BIT             2
`define EN_SHAKE_BIT            3
`define EN_TILT35_BIT           4
`define EN_AUTOCLR_BIT          6
`define EN_SAMPLE_BIT           7

`define MC_TILTFLIP_BIT         0
`define MC_MOVE_BIT             2
`define MC_SHAKE_BIT            3
`define MC_TILT35_BIT           4

`define MODE_LOW_WDT_BIT        4
`define MODE_HIGH_WDT_BIT       5

`define STATE_SLEEP             2'h0
`define STATE_WAKE              2'h1
`define STATE_STANDBY           2'h3
`define STATE_RESERVED          2'h2

`define RATE_FIXED_BITS         5'h01

`define WDT_CYCLES_DEFAULT      16'h0800

`endif

// *** accel_ctl_pkg.sv ***
// types shared by the control and status bank
package accel_ctl_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] rate_t;
    typedef logic [4:0] source_t;
endpackage

// *** pin_sync.sv ***
// two-flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module pin_sync
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed
    {
        logic meta;
        logic level;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    always_comb
    begin
        s_d.meta  = pin_i;
        s_d.level = s_q.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level_o = s_q.level;
endmodule

// *** stall_watchdog.sv ***
// serial clock stall watchdog: pulses when the clock holds one level too long
`timescale 1ns/1ps
`include "accel_ctl_regs.svh"
module stall_watchdog
#(
    parameter logic [15:0] LIMIT = `WDT_CYCLES_DEFAULT
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic low_en_i,
    input  wire logic high_en_i,
    output logic      event_o
);
    typedef struct packed
    {
        logic        last;
        logic [15:0] count;
        logic        fired;
        logic        event_p;
    } wdt_s;

    wdt_s s_q;
    wdt_s s_d;
    logic armed;

    always_comb
    begin
        s_d         = s_q;
        s_d.last    = scl_i;
        s_d.event_p = 1'b0;
        armed       = scl_i ? high_en_i : low_en_i;
        if (scl_i != s_q.last || !armed)
        begin
            s_d.count = '0;
            s_d.fired = 1'b0;
        end
        else if (!s_q.fired)
        begin
            if (s_q.count == LIMIT - 16'h0001)
            begin
                s_d.fired   = 1'b1;
                s_d.event_p = 1'b1;
            end
            else
                s_d.count = s_q.count + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign event_o = s_q.event_p;
endmodule

// *** accel_control_status_regs.sv ***
// control and status register bank of the motion sensor core
// How it works
// [R1] status state field reads 00 while asleep, 01 while sampling.
// [R2] resolution indicator always reads 0, high resolution.
// [R3] reading the status register clears the bus stall flag.
// [R4] a watchdog event resets the slave machine to idle and sets the flag.
// [R5] memory-busy bit reads 1 while one-time memory is active.
// [R6] tilt status reported only with tilt enable and tilt/flip feature enable.
// [R7] flip status reported only with flip enable and tilt/flip feature enable.
// [R8] movement status reported only with its enable and movement feature enable.
// [R9] shake status needs shake enable, shake feature and movement feature.
// [R10] tilt-35 status needs its enable, tilt-35 feature and movement feature.
// [R11] autoclear off: pending clears on status write; on: clears when condition ends.
// [R12] per-sample enable sets the per-sample flag after every sample.
// [R13] fifo interrupts are not gated by the source enable register.
// [R14] mode register accepts writes in every operating state.
// [R15] state field selects sleep 00, wake 01, standby 11; 10 reserved.
// [R16] mode bit 4 enables the low stall watchdog, off after reset.
// [R17] mode bit 5 enables the high stall watchdog, off after reset.
// [R18] host writes rate register with bits 7:4 zero, bit 3 one.
// [R19] rate codes 0 to 7 select 50 up to 2000 Hz.
// [R20] rate code also sets oscillator frequency; internal rate equals output.
// [R21] stall timeout length is a parameter in oscillator cycles.
`timescale 1ns/1ps
`include "accel_ctl_regs.svh"
module accel_control_status_regs
#(
    parameter logic [15:0] WDT_CYCLES = `WDT_CYCLES_DEFAULT // see [R21]
)
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   wr_en_i,
    input  wire logic                   rd_en_i,
    input  wire logic [7:0]             addr_i,
    input  wire accel_ctl_pkg::byte_t   wdata_i,
    output accel_ctl_pkg::byte_t        rdata_o,
    input  wire logic                   scl_i,
    input  wire logic                   otp_busy_i,
    input  wire logic                   sample_done_i,
    input  wire accel_ctl_pkg::source_t motion_cond_i,
    input  wire accel_ctl_pkg::byte_t   motion_ctrl_i,
    input  wire logic                   fifo_irq_i,
    output logic                        slave_idle_o,
    output logic                        clocks_run_o,
    output logic                        sampling_o,
    output accel_ctl_pkg::rate_t        rate_code_o,
    output accel_ctl_pkg::source_t      pending_o,
    output logic                        per_sample_flag_o,
    output logic                        fifo_irq_o,
    output logic                        irq_o
);
    import accel_ctl_pkg::*;

    typedef enum logic [1:0] {ST_SLEEP, ST_WAKE, ST_STANDBY} op_state_e;

    typedef struct packed
    {
        byte_t     source_en;
        logic [1:0] mode_state;
        logic      low_wdt_en;
        logic      high_wdt_en;
        rate_t     rate;
        op_state_e op;
        logic      stall_flag;
        source_t   pending;
        logic      sample_flag;
        byte_t     rdata;
        logic      idle;
        logic      clocks;
        logic      sampling;
        logic      fifo_irq;
        logic      irq;
    } regs_s;

    regs_s   s_q;
    regs_s   s_d;
    logic    scl_sync;
    logic    wdt_event;
    source_t gate;
    source_t cond_ok;
    logic    rd_status;
    logic    wr_status;

    pin_sync u_scl_sync
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (scl_i),
        .level_o (scl_sync)
    );

    stall_watchdog #(.LIMIT(WDT_CYCLES)) u_wdt
    (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .scl_i     (scl_sync),
        .low_en_i  (s_q.low_wdt_en),  // see [R16]
        .high_en_i (s_q.high_wdt_en), // see [R17]
        .event_o   (wdt_event)
    );

    always_comb
    begin
        s_d       = s_q;
        rd_status = rd_en_i && addr_i == `ADDR_DEVICE_CONDITION;
        wr_status = wr_en_i && addr_i == `ADDR_PENDING_STATUS;

        // feature gating of each motion source
        gate[`EN_TILT_BIT]   = s_q.source_en[`EN_TILT_BIT]
                               && motion_ctrl_i[`MC_TILTFLIP_BIT]; // see [R6]
        gate[`EN_FLIP_BIT]   = s_q.source_en[`EN_FLIP_BIT]
                               && motion_ctrl_i[`MC_TILTFLIP_BIT]; // see [R7]
        gate[`EN_MOVE_BIT]   = s_q.source_en[`EN_MOVE_BIT]
                               && motion_ctrl_i[`MC_MOVE_BIT]; // see [R8]
        gate[`EN_SHAKE_BIT]  = s_q.source_en[`EN_SHAKE_BIT]
                               && motion_ctrl_i[`MC_SHAKE_BIT]
                               && motion_ctrl_i[`MC_MOVE_BIT]; // see [R9]
        gate[`EN_TILT35_BIT] = s_q.source_en[`EN_TILT35_BIT]
                               && motion_ctrl_i[`MC_TILT35_BIT]
                               && motion_ctrl_i[`MC_MOVE_BIT]; // see [R10]
        cond_ok = motion_cond_i & gate;

        // register writes, accepted in every state
        if (wr_en_i)
        begin
            unique case (addr_i)
                `ADDR_SOURCE_ENABLE:
                    s_d.source_en = wdata_i;
                `ADDR_STATE_SELECT:
                begin
                    s_d.mode_state  = wdata_i[1:0]; // see [R14]
                    s_d.low_wdt_en  = wdata_i[`MODE_LOW_WDT_BIT];
                    s_d.high_wdt_en = wdata_i[`MODE_HIGH_WDT_BIT];
                end
                `ADDR_RATE_SELECT:
                    s_d.rate = wdata_i[2:0]; // see [R18]
                default:
                    s_d.rate = s_q.rate;
            endcase
        end

        // reserved state code keeps the previous operating state
        unique case (s_d.mode_state)
            `STATE_SLEEP:   s_d.op = ST_SLEEP;   // see [R15]
            `STATE_WAKE:    s_d.op = ST_WAKE;
            `STATE_STANDBY: s_d.op = ST_STANDBY;
            default:        s_d.op = s_q.op;
        endcase

        // stall flag: set wins over the read clear
        if (wdt_event)
            s_d.stall_flag = 1'b1; // see [R4]
        else if (rd_status)
            s_d.stall_flag = 1'b0; // see [R3]
        s_d.idle = !wdt_event; // see [R4]

        // pending sources: new events win over clears
        if (s_q.source_en[`EN_AUTOCLR_BIT])
            s_d.pending = s_q.pending & cond_ok; // see [R11]
        else if (wr_status)
            s_d.pending = '0; // see [R11]
        s_d.pending = s_d.pending | cond_ok;

        if (sample_done_i && s_q.sampling && s_q.source_en[`EN_SAMPLE_BIT])
            s_d.sample_flag = 1'b1; // see [R12]
        else if (wr_status)
            s_d.sample_flag = 1'b0;

        s_d.clocks   = s_d.op != ST_SLEEP;
        s_d.sampling = s_d.op == ST_WAKE;
        s_d.fifo_irq = fifo_irq_i; // see [R13]
        s_d.irq      = (|s_d.pending) || s_d.sample_flag || fifo_irq_i;

        // read data
        s_d.rdata = `RST_BYTE;
        if (rd_en_i)
        begin
            unique case (addr_i)
                `ADDR_DEVICE_CONDITION:
                begin
                    s_d.rdata[1:0] = (s_q.op == ST_WAKE) ? `STATE_WAKE
                                                         : `STATE_SLEEP; // see [R1]
                    s_d.rdata[`COND_RES_BIT]   = 1'b0;        // see [R2]
                    s_d.rdata[`COND_STALL_BIT] = s_q.stall_flag;
                    s_d.rdata[`COND_BUSY_BIT]  = otp_busy_i;  // see [R5]
                end
                `ADDR_SOURCE_ENABLE:
                    s_d.rdata = s_q.source_en;
                `ADDR_STATE_SELECT:
                begin
                    s_d.rdata[1:0] = s_q.mode_state;
                    s_d.rdata[`MODE_LOW_WDT_BIT]  = s_q.low_wdt_en;
                    s_d.rdata[`MODE_HIGH_WDT_BIT] = s_q.high_wdt_en;
                end
                `ADDR_RATE_SELECT:
                    s_d.rdata = {`RATE_FIXED_BITS, s_q.rate}; // see [R19]
                default:
                    s_d.rdata = `RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q      <= '0;
            s_q.op   <= ST_SLEEP;
            s_q.idle <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign rdata_o           = s_q.rdata;
    assign slave_idle_o      = s_q.idle;
    assign clocks_run_o      = s_q.clocks;
    assign sampling_o        = s_q.sampling;
    assign rate_code_o       = s_q.rate; // see [R20]
    assign pending_o         = s_q.pending;
    assign per_sample_flag_o = s_q.sample_flag;
    assign fifo_irq_o        = s_q.fifo_irq;
    assign irq_o             = s_q.irq;

    stall_flag_set_a: assert property ( // see [R4]
        @(posedge clk_i) disable iff (!rst_n_i)
        wdt_event |=> s_q.stall_flag && !slave_idle_o)
        else $error("stall flag not set after watchdog event");
    idle_pulse_a: assert property ( // see [R4]
        @(posedge clk_i) disable iff (!rst_n_i)
        !slave_idle_o |=> slave_idle_o)
        else $error("slave idle request longer than one cycle");
    stall_read_clear_a: assert property ( // see [R3]
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_status && !wdt_event |=> !s_q.stall_flag)
        else $error("status read did not clear stall flag");
    stall_hold_a: assert property ( // see [R3]
        @(posedge clk_i) disable iff (!rst_n_i)
        !rd_status && !wdt_event |=> $stable(s_q.stall_flag))
        else $error("stall flag changed without event or read");

    state_report_a: assert property ( // see [R1]
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_status |=> rdata_o[1:0] == (sampling_o ? `STATE_WAKE : `STATE_SLEEP))
        else $error("status state field wrong");
    res_bit_zero_a: assert property ( // see [R2]
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_status |=> !rdata_o[`COND_RES_BIT])
        else $error("resolution indicator not zero");
    busy_report_a: assert property ( // see [R5]
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_status |=> rdata_o[`COND_BUSY_BIT] == $past(otp_busy_i))
        else $error("memory busy bit wrong");
    read_stands_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !rd_en_i |=> rdata_o == `RST_BYTE)
        else $error("read data not cleared after read");

    tilt_gate_a: assert property ( // see [R6]
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(pending_o[`EN_TILT_BIT])
        |-> $past(s_q.source_en[`EN_TILT_BIT] && motion_ctrl_i[`MC_TILTFLIP_BIT]))
        else $error("tilt reported without enables");
    flip_gate_a: assert property ( // see [R7]
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(pending_o[`EN_FLIP_BIT])
        |-> $past(s_q.source_en[`EN_FLIP_BIT] && motion_ctrl_i[`MC_TILTFLIP_BIT]))
        else $error("flip reported without enables");
    move_gate_a: assert property ( // see [R8]
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(pending_o[`EN_MOVE_BIT])
        |-> $past(s_q.source_en[`EN_MOVE_BIT] && motion_ctrl_i[`MC_MOVE_BIT]))
        else $error("movement reported without enables");
    shake_gate_a: assert property ( // see [R9]
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(pending_o[`EN_SHAKE_BIT])
        |-> $past(s_q.source_en[`EN_SHAKE_BIT] && motion_ctrl_i[`MC_SHAKE_BIT]
                  && motion_ctrl_i[`MC_MOVE_BIT]))
        else $error("shake reported without features");
    tilt35_gate_a: assert property ( // see [R10]
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(pending_o[`EN_TILT35_BIT])
        |-> $past(s_q.source_en[`EN_TILT35_BIT] && motion_ctrl_i[`MC_TILT35_BIT]
                  && motion_ctrl_i[`MC_MOVE_BIT]))
        else $error("tilt-35 reported without features");

    manual_hold_a: assert property ( // see [R11]
        @(posedge clk_i) disable iff (!rst_n_i)
        !s_q.source_en[`EN_AUTOCLR_BIT] && !wr_status && pending_o[`EN_MOVE_BIT]
        |=> pending_o[`EN_MOVE_BIT])
        else $error("pending cleared without status write");
    auto_clear_a: assert property ( // see [R11]
        @(posedge clk_i) disable iff (!rst_n_i)
        s_q.source_en[`EN_AUTOCLR_BIT] && !motion_cond_i[`EN_MOVE_BIT]
        |=> !pending_o[`EN_MOVE_BIT])
        else $error("pending kept after condition ended");
    status_clear_a: assert property ( // see [R11]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_status && !(|cond_ok) |=> pending_o == '0)
        else $error("status write did not clear pending");

    sample_set_a: assert property ( // see [R12]
        @(posedge clk_i) disable iff (!rst_n_i)
        sample_done_i && sampling_o && s_q.source_en[`EN_SAMPLE_BIT]
        |=> per_sample_flag_o)
        else $error("per-sample flag not set");
    sample_gate_a: assert property ( // see [R12]
        @(posedge clk_i) disable iff (!rst_n_i)
        !s_q.source_en[`EN_SAMPLE_BIT] && !per_sample_flag_o |=> !per_sample_flag_o)
        else $error("per-sample flag set while disabled");
    fifo_pass_a: assert property ( // see [R13]
        @(posedge clk_i) disable iff (!rst_n_i)
        fifo_irq_i |=> fifo_irq_o && irq_o)
        else $error("fifo interrupt gated");

    mode_accept_a: assert property ( // see [R14]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_STATE_SELECT |=> s_q.mode_state == $past(wdata_i[1:0]))
        else $error("mode write not taken");
    wdt_enables_a: assert property ( // see [R16] [R17]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_STATE_SELECT
        |=> s_q.low_wdt_en == $past(wdata_i[`MODE_LOW_WDT_BIT])
            && s_q.high_wdt_en == $past(wdata_i[`MODE_HIGH_WDT_BIT]))
        else $error("watchdog enables not taken");
    mode_wake_a: assert property ( // see [R15]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_STATE_SELECT && wdata_i[1:0] == `STATE_WAKE
        |=> sampling_o && clocks_run_o)
        else $error("wake write did not start sampling");
    sleep_state_a: assert property ( // see [R15]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_STATE_SELECT && wdata_i[1:0] == `STATE_SLEEP
        |=> !sampling_o && !clocks_run_o)
        else $error("sleep write left clocks running");
    standby_state_a: assert property ( // see [R15]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_STATE_SELECT && wdata_i[1:0] == `STATE_STANDBY
        |=> !sampling_o && clocks_run_o)
        else $error("standby state wrong");
    reserved_hold_a: assert property ( // see [R15]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_STATE_SELECT && wdata_i[1:0] == `STATE_RESERVED
        |=> $stable(sampling_o) && $stable(clocks_run_o))
        else $error("reserved state code changed state");

    rate_write_a: assert property ( // see [R20]
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `ADDR_RATE_SELECT |=> rate_code_o == $past(wdata_i[2:0]))
        else $error("rate code not taken");
    rate_read_a: assert property ( // see [R19]
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_en_i && !wr_en_i && addr_i == `ADDR_RATE_SELECT
        |=> rdata_o == {`RATE_FIXED_BITS, rate_code_o})
        else $error("rate readback wrong");
endmodule

// *** host_model.sv ***
// host model: drives the register strobes and the serial clock pin
`timescale 1ns/1ps
module host_model
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            scl_o
);
    initial
    begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        scl_o   = 1'b1;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        // released bus shows no stale value
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_en_o <= 1'b1;
        addr_o  <= a;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        addr_o  <= ~a;
        #1 d = rdata_i;
    endtask

    task automatic write_rate(input logic [2:0] c);
        write_reg(8'h08, {4'h0, 1'b1, c});
    endtask

    // poll until one-time memory is idle, giving up after 50 reads
    task automatic wait_ready;
        logic [7:0] s;
        s = 8'h80;
        for (int i = 0; i < 50 && s[7] !== 1'b0; i++)
            read_reg(8'h05, s);
    endtask

    // link clock bursts at 400 ns, stands high between them
    task automatic scl_frame(input int n);
        repeat (n)
        begin
            #200 scl_o <= 1'b0;
            #200 scl_o <= 1'b1;
        end
    endtask

    task automatic stall_low(input int ns);
        scl_o <= 1'b0;
        #(ns) scl_o <= 1'b1;
    endtask
endmodule

// *** test_accel_control_status_regs.sv ***
// self-checking bench of the control and status register bank
`timescale 1ns/1ps
module test_accel_control_status_regs;
    import accel_ctl_pkg::*;
    logic    clk_i, rst_n_i, wr_en, rd_en, scl, busy, done, fin;
    logic    idle, run, smp, psf, fout, irq;
    byte_t   addr, wdata, rdata, mc, en, rd;
    source_t cond, pend, e;
    rate_t   rate;
    int      mismatches, n_checks, idle_pulses;
    logic [1:0] mcode [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1};

    accel_control_status_regs #(.WDT_CYCLES(16'h0010)) uut
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .scl_i(scl),
        .otp_busy_i(busy), .sample_done_i(done), .motion_cond_i(cond),
        .motion_ctrl_i(mc), .fifo_irq_i(fin), .slave_idle_o(idle),
        .clocks_run_o(run), .sampling_o(smp), .rate_code_o(rate),
        .pending_o(pend), .per_sample_flag_o(psf), .fifo_irq_o(fout), .irq_o(irq)
    );

    host_model host
    (
        .clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata), .scl_o(scl)
    );

    function automatic source_t gate(input byte_t en, input byte_t mc);
        gate = en[4:0] & {mc[4] & mc[2], mc[3] & mc[2], mc[2], mc[0], mc[0]};
    endfunction

    function automatic byte_t stat(input logic b, input logic w, input logic wake);
        stat = {b, 2'h0, w, 3'h0, wake};
    endfunction

    task automatic check(input string w, input byte_t seen, input byte_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", w, exp, seen);
        end
    endtask

    task automatic rchk(input string w, input byte_t a, input byte_t exp);
        host.read_reg(a, rd);
        check(w, rd, exp);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
        if (rst_n_i === 1'b1 && idle === 1'b0)
            idle_pulses++;

    initial
    begin
        #1_000_000;
        mismatches++;
        close_out();
    end

    initial
    begin
        {rst_n_i, busy, done, fin, cond, mc} = '0;
        void'($urandom(32'h78f4_8543));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        tick(1);
        check("slave idle", 8'(idle), 8'h01);
        rchk("status rst", 8'h05, 8'h00);
        rchk("enable rst", 8'h06, 8'h00);
        rchk("mode rst", 8'h07, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            host.write_reg(8'h07, {6'h00, mcode[i]});
            rchk("state field", 8'h05, stat(0, 0, 1'(5'h11 >> i)));
            check("clocks run", 8'(run), 8'(1'(5'h17 >> i)));
            check("sampling", 8'(smp), 8'(1'(5'h11 >> i)));
        end
        for (int c = 0; c < 8; c++)
        begin
            host.write_rate(3'(c));
            rchk("rate reg", 8'h08, 8'(8 + c));
            check("rate code", 8'(rate), 8'(c));
        end
        for (int k = 0; k < 2; k++)
        begin
            host.write_reg(8'h06, k ? 8'h80 : 8'h00);
            @(posedge clk_i) done <= 1'b1;
            @(posedge clk_i) done <= 1'b0;
            tick(2);
            check("sample flag", 8'(psf), 8'(k));
            check("irq", 8'(irq), 8'(k));
            host.write_reg(8'h14, 8'h00);
            tick(1);
            check("flag clear", 8'(psf), 8'h00);
        end
        host.write_reg(8'h07, 8'h11);
        host.scl_frame(4);
        tick(2);
        check("no stall", 8'(idle_pulses), 8'h00);
        host.stall_low(1500);
        tick(5);
        check("low stall", 8'(idle_pulses), 8'h01);
        rchk("stall flag", 8'h05, stat(0, 1, 1));
        rchk("flag cleared", 8'h05, stat(0, 0, 1));
        host.write_reg(8'h07, 8'h21);
        tick(30);
        check("high stall", 8'(idle_pulses), 8'h02);
        host.write_reg(8'h07, 8'h01);
        rchk("high flag", 8'h05, stat(0, 1, 1));
        host.write_reg(8'h06, 8'h00);
        @(posedge clk_i) fin <= 1'b1;
        tick(3);
        check("fifo irq", {6'h00, fout, irq}, 8'h03);
        @(posedge clk_i) fin <= 1'b0;
        @(posedge clk_i) busy <= 1'b1;
        tick(2);
        rchk("otp busy", 8'h05, stat(1, 0, 1));
        @(posedge clk_i) busy <= 1'b0;
        host.wait_ready();
        for (int i = 0; i < 24; i++)
        begin
            en = i < 2 ? 8'h1f : 8'($urandom) & 8'h1f;
            host.write_reg(8'h06, en);
            @(posedge clk_i);
            mc <= i == 0 ? 8'h1d : i == 1 ? 8'h19 : 8'($urandom);
            cond <= i < 2 ? 5'h1f : 5'($urandom);
            tick(3);
            e = cond & gate(en, mc);
            check("pending", 8'(pend), 8'(e));
            check("irq or", 8'(irq), 8'(|e));
            @(posedge clk_i) cond <= 5'h00;
            tick(3);
            check("held", 8'(pend), 8'(e));
            host.write_reg(8'h14, 8'h00);
            tick(1);
            check("cleared", 8'(pend), 8'h00);
        end
        host.write_reg(8'h06, 8'h44);
        @(posedge clk_i);
        mc <= 8'h04;
        cond <= 5'h04;
        tick(3);
        check("auto set", 8'(pend), 8'h04);
        @(posedge clk_i) cond <= 5'h00;
        tick(3);
        check("auto clear", 8'(pend), 8'h00);
        close_out();
    end
endmodule
